// file: common/hipe_defines.svh
// Purpose: constants of the hart interrupt pending/enable block
// Assumes: included by bare name
// Notes: bit position of a cause equals its cause number
`ifndef HIPE_DEFINES_SVH
`define HIPE_DEFINES_SVH

`define HIPE_VEC_W 16
`define HIPE_CAUSE_W 4
`define HIPE_BIT_SSI 1
`define HIPE_BIT_MSI 3
`define HIPE_BIT_STI 5
`define HIPE_BIT_MTI 7
`define HIPE_BIT_SEI 9
`define HIPE_BIT_MEI 11
`define HIPE_M_MASK 16'h0888
`define HIPE_S_MASK 16'h0222
`define HIPE_STD_MASK 16'h0aaa
`define HIPE_RST_VEC 16'h0000
`define HIPE_RST_CAUSE 4'h0

`endif

// file: common/hipe_pkg.sv
// Purpose: types of the hart interrupt pending/enable block
// Assumes: hipe_defines.svh on the include path
// Notes: one-hot codes for operations and register views
`include "hipe_defines.svh"
package hipe_pkg;

    typedef enum logic [1:0] {
        HIPE_PRIV_U = 2'h0,
        HIPE_PRIV_S = 2'h1,
        HIPE_PRIV_M = 2'h3
    } hipe_priv_t;

    typedef enum logic [2:0] {
        HIPE_OP_WRITE = 3'h1,
        HIPE_OP_SET = 3'h2,
        HIPE_OP_CLEAR = 3'h4
    } hipe_op_t;

    typedef enum logic [3:0] {
        HIPE_SEL_PEND = 4'h1,
        HIPE_SEL_ENA = 4'h2,
        HIPE_SEL_SPEND = 4'h4,
        HIPE_SEL_SENA = 4'h8
    } hipe_sel_t;

    typedef struct packed {
        logic valid;
        hipe_op_t op;
        hipe_sel_t sel;
        logic [`HIPE_VEC_W-1:0] wdata;
    } hipe_csr_req_t;

    typedef struct packed {
        hipe_priv_t priv;
        logic m_ie;
        logic s_ie;
    } hipe_hart_t;

endpackage

// file: src/hipe_sync.sv
// Purpose: two-flop synchroniser for asynchronous request pins
// Assumes: inputs are levels
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module hipe_sync #(
    parameter int W = 2
) (
    clk,
    srst,
    d,
    q
);
    input wire logic clk;
    input wire logic srst;
    input wire logic [W-1:0] d;
    output logic [W-1:0] q;

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // hipe_sync
`default_nettype wire

// file: src/hipe_prio.sv
// Purpose: fixed-priority pick among takeable interrupts
// Assumes: take has pending, enable and global enable folded in
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
`include "hipe_defines.svh"
module hipe_prio (
    take,
    to_m,
    found,
    cause
);
    input wire logic [`HIPE_VEC_W-1:0] take;
    input wire logic [`HIPE_VEC_W-1:0] to_m;
    output logic found;
    output logic [`HIPE_CAUSE_W-1:0] cause;

    // lowest priority first, so the last hit of the scan wins
    localparam int ORD[6] = '{`HIPE_BIT_STI, `HIPE_BIT_SSI, `HIPE_BIT_SEI,
        `HIPE_BIT_MTI, `HIPE_BIT_MSI, `HIPE_BIT_MEI};

    // platform causes would be scanned after this loop to rank first
    always_comb begin
        found = 1'b0;
        cause = `HIPE_RST_CAUSE;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 6; k++) begin
                if (take[ORD[k]] && (to_m[ORD[k]] == (p == 1))) begin
                    found = 1'b1;
                    cause = ORD[k][`HIPE_CAUSE_W-1:0];
                end
            end
        end
    end
endmodule // hipe_prio
`default_nettype wire

// file: src/hipe_core.sv
// Purpose: per-hart pending/enable vectors, global enable and selection
// Assumes: csr_req comes from core logic on clk; external and timer irq pins are asynchronous
// Notes: read data returns the value before a same-cycle update
// Function
// - cause i maps to bit i
// - low sixteen bits hold standard causes only
// - take when pending, enabled, globally enabled
// - undelegated: below M, or M with enable
// - writing zero clears writable pending bit
// - unimplemented enable bits read zero
// - pending layout 11,9,7,5,3,1
// - enable layout matches pending layout
// - no non-maskable interrupt in pending
// - external controller alone drives machine external
// - machine timer pending is read-only
// - machine software pending read-only, mmio driven
// - no supervisor: supervisor bits zero
// - supervisor external is latch OR request
// - reads OR, set/clear use latch only
// - supervisor timer pending software writable
// - supervisor software pending software writable
// - higher destination first, then fixed order
// - interrupts beat synchronous exceptions
// - platform causes get platform priority
// - supervisor views show delegated bits only
// - delegation vector shares pending layout
// - delegated interrupts masked at delegator level
`timescale 1ns/1ps
`default_nettype none
`include "hipe_defines.svh"
module hipe_core
    import hipe_pkg::*;
#(
    parameter bit SUP_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic srst,
    input wire hipe_csr_req_t csr_req,
    output logic [`HIPE_VEC_W-1:0] csr_rdata,
    output logic csr_rvalid,
    input wire hipe_hart_t hart,
    input wire logic [`HIPE_VEC_W-1:0] deleg,
    input wire logic m_ext_irq,
    input wire logic s_ext_irq,
    input wire logic m_timer_irq,
    input wire logic m_soft_irq,
    input wire logic exc_pending,
    output logic irq_req,
    output logic [`HIPE_CAUSE_W-1:0] irq_cause,
    output logic exc_take
);

    localparam logic [`HIPE_VEC_W-1:0] S_IMPL =
        SUP_PRESENT ? `HIPE_S_MASK : `HIPE_RST_VEC;
    localparam logic [`HIPE_VEC_W-1:0] IMPL = `HIPE_M_MASK | S_IMPL;

    logic [2:0] pins_s;
    logic supervisor_external_pending_sw_reg;
    logic supervisor_timer_pending_reg;
    logic supervisor_software_pending_reg;
    logic [`HIPE_VEC_W-1:0] enable_reg;
    logic [`HIPE_VEC_W-1:0] pend_view;
    logic [`HIPE_VEC_W-1:0] pend_rmw;
    logic [`HIPE_VEC_W-1:0] dlg;
    logic [`HIPE_VEC_W-1:0] old_val;
    logic [`HIPE_VEC_W-1:0] new_val;
    logic [`HIPE_VEC_W-1:0] wmask;
    logic [`HIPE_VEC_W-1:0] gen;
    logic [`HIPE_VEC_W-1:0] take;
    logic take_found;
    logic [`HIPE_CAUSE_W-1:0] take_cause;
    logic wr_pend;
    logic wr_ena;

    // apply a write, set or clear to an old value
    function automatic logic [`HIPE_VEC_W-1:0] rmw(
        input hipe_op_t op,
        input logic [`HIPE_VEC_W-1:0] old,
        input logic [`HIPE_VEC_W-1:0] wd
    );
        logic [`HIPE_VEC_W-1:0] r;
        r = old;
        unique case (op)
            HIPE_OP_WRITE: r = wd;
            HIPE_OP_SET: r = old | wd;
            HIPE_OP_CLEAR: r = old & ~wd;
            default: r = old;
        endcase
        return r;
    endfunction

    // external and timer requests arrive from other domains
    hipe_sync #(
        .W(3)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .d({s_ext_irq, m_timer_irq, m_ext_irq}),
        .q(pins_s)
    );

    // delegation shares the pending layout; machine bits never delegate
    assign dlg = deleg & S_IMPL;

    // no non-maskable source in this vector
    // supervisor external seen as latch OR controller request
    always_comb begin
        pend_view = `HIPE_RST_VEC;
        pend_view[`HIPE_BIT_MEI] = pins_s[0];
        pend_view[`HIPE_BIT_MTI] = pins_s[1];
        pend_view[`HIPE_BIT_MSI] = m_soft_irq;
        pend_view[`HIPE_BIT_SEI] = SUP_PRESENT & (supervisor_external_pending_sw_reg | pins_s[2]);
        pend_view[`HIPE_BIT_STI] = SUP_PRESENT & supervisor_timer_pending_reg;
        pend_view[`HIPE_BIT_SSI] = SUP_PRESENT & supervisor_software_pending_reg;
    end

    // set and clear operate on the software latch only
    always_comb begin
        pend_rmw = pend_view;
        pend_rmw[`HIPE_BIT_SEI] = SUP_PRESENT & supervisor_external_pending_sw_reg;
    end

    // supervisor views expose delegated bits only
    always_comb begin
        old_val = `HIPE_RST_VEC;
        wmask = `HIPE_RST_VEC;
        unique case (csr_req.sel)
            HIPE_SEL_PEND: begin
                old_val = (csr_req.op == HIPE_OP_WRITE) ? pend_view : pend_rmw;
                wmask = S_IMPL;
            end
            HIPE_SEL_ENA: begin
                old_val = enable_reg;
                wmask = IMPL;
            end
            HIPE_SEL_SPEND: begin
                old_val = pend_view & dlg;
                wmask = dlg & (16'h0001 << `HIPE_BIT_SSI);
            end
            HIPE_SEL_SENA: begin
                old_val = enable_reg & dlg;
                wmask = dlg;
            end
            default: begin
                old_val = `HIPE_RST_VEC;
                wmask = `HIPE_RST_VEC;
            end
        endcase
        new_val = rmw(csr_req.op, old_val, csr_req.wdata);
    end

    assign wr_pend = csr_req.valid &&
        (csr_req.sel == HIPE_SEL_PEND || csr_req.sel == HIPE_SEL_SPEND);
    assign wr_ena = csr_req.valid &&
        (csr_req.sel == HIPE_SEL_ENA || csr_req.sel == HIPE_SEL_SENA);

    // read data holds the pre-update value for one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            csr_rdata <= `HIPE_RST_VEC;
            csr_rvalid <= 1'b0;
        end else begin
            csr_rvalid <= csr_req.valid;
            csr_rdata <= csr_req.valid ?
                ((csr_req.sel == HIPE_SEL_PEND) ? pend_view : old_val) :
                `HIPE_RST_VEC;
        end
    end

    // writable pending bits cleared by writing zero
    // machine pending bits have no write path
    // machine software level comes from memory-mapped logic
    always_ff @(posedge clk) begin
        if (srst) begin
            supervisor_external_pending_sw_reg <= 1'b0;
            supervisor_timer_pending_reg <= 1'b0;
            supervisor_software_pending_reg <= 1'b0;
        end else if (wr_pend) begin
            if (wmask[`HIPE_BIT_SEI]) begin
                supervisor_external_pending_sw_reg <= new_val[`HIPE_BIT_SEI];
            end
            if (wmask[`HIPE_BIT_STI]) begin
                supervisor_timer_pending_reg <= new_val[`HIPE_BIT_STI];
            end
            if (wmask[`HIPE_BIT_SSI]) begin
                supervisor_software_pending_reg <= new_val[`HIPE_BIT_SSI];
            end
        end
    end

    // only implemented enable bits hold state
    // supervisor bits are absent from the masks without supervisor
    always_ff @(posedge clk) begin
        if (srst) begin
            enable_reg <= `HIPE_RST_VEC;
        end else if (wr_ena) begin
            enable_reg <= (enable_reg & ~wmask) | (new_val & wmask);
        end
    end

    // delegated causes masked in machine mode
    always_comb begin
        gen = `HIPE_RST_VEC;
        for (int i = 0; i < `HIPE_VEC_W; i++) begin
            if (dlg[i]) begin
                gen[i] = (hart.priv == HIPE_PRIV_S && hart.s_ie) ||
                    hart.priv == HIPE_PRIV_U;
            end else begin
                gen[i] = hart.priv != HIPE_PRIV_M || hart.m_ie;
            end
        end
    end

    // cause number is the bit index
    // pending and enabled and globally enabled
    assign take = pend_view & enable_reg & gen;

    hipe_prio u_prio (
        .take(take),
        .to_m(~dlg),
        .found(take_found),
        .cause(take_cause)
    );

    // registered request and cause each cycle
    // exception only when no interrupt is takeable
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_req <= 1'b0;
            irq_cause <= `HIPE_RST_CAUSE;
            exc_take <= 1'b0;
        end else begin
            irq_req <= take_found;
            irq_cause <= take_found ? take_cause : `HIPE_RST_CAUSE;
            exc_take <= exc_pending && !take_found;
        end
    end

    // previous-cycle copies, for checks on the registered outputs
    logic [`HIPE_VEC_W-1:0] take_d_reg;
    logic [`HIPE_VEC_W-1:0] dlg_d_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            take_d_reg <= `HIPE_RST_VEC;
            dlg_d_reg <= `HIPE_RST_VEC;
        end else begin
            take_d_reg <= take;
            dlg_d_reg <= dlg;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_pend_write_zero;
        csr_req.valid && csr_req.op == HIPE_OP_WRITE &&
            csr_req.sel == HIPE_SEL_PEND && !csr_req.wdata[`HIPE_BIT_SSI];
    endsequence

    sequence s_supervisor_external_pending_set_nothing;
        csr_req.valid && csr_req.op == HIPE_OP_SET &&
            csr_req.sel == HIPE_SEL_PEND && !csr_req.wdata[`HIPE_BIT_SEI];
    endsequence

    a_take_cause_valid: assert property (
        irq_req |-> take_d_reg[irq_cause])
        else $error("request without takeable cause");

    a_mode_m_masked: assert property (
        ($past(hart.priv) == HIPE_PRIV_M && !$past(hart.m_ie)) |-> !irq_req)
        else $error("request in machine mode with enable off");

    a_deleg_masked_m: assert property (
        (irq_req && $past(hart.priv) == HIPE_PRIV_M) |-> !dlg_d_reg[irq_cause])
        else $error("delegated cause taken in machine mode");

    a_write_zero_clear: assert property (
        (s_pend_write_zero ##1 !csr_req.valid) |-> !pend_view[`HIPE_BIT_SSI])
        else $error("pending bit not cleared by zero write");

    a_supervisor_external_pending_rmw_latch: assert property (
        s_supervisor_external_pending_set_nothing |=> supervisor_external_pending_sw_reg == $past(supervisor_external_pending_sw_reg))
        else $error("set op disturbed external latch");

    a_read_reserved_zero: assert property (
        csr_rvalid |-> (csr_rdata & ~IMPL) == `HIPE_RST_VEC)
        else $error("reserved bit read nonzero");

    a_exc_yields_irq: assert property (
        exc_take |-> !irq_req && $past(exc_pending))
        else $error("exception taken with interrupt pending");

    a_prio_mei_first: assert property (
        $past(take[`HIPE_BIT_MEI] && !dlg[`HIPE_BIT_MEI]) |->
            irq_cause == `HIPE_BIT_MEI)
        else $error("machine external not chosen first");

    a_sview_deleg_only: assert property (
        (csr_req.valid && csr_req.sel == HIPE_SEL_SENA) |=>
            (csr_rdata & ~$past(dlg)) == `HIPE_RST_VEC)
        else $error("supervisor view shows undelegated bit");

    a_machine_timer_pending_write_immune: assert property (
        ((csr_req.valid && csr_req.sel == HIPE_SEL_PEND) ##1 $stable(pins_s[1])) |->
            $stable(pend_view[`HIPE_BIT_MTI]))
        else $error("pending write moved timer pending");

    a_rvalid_next: assert property (
        csr_req.valid |=> csr_rvalid)
        else $error("access without read valid");

    a_cause_idle_zero: assert property (
        !irq_req |-> irq_cause == `HIPE_RST_CAUSE)
        else $error("cause nonzero without request");

    a_enable_unimpl_zero: assert property (
        (enable_reg & ~IMPL) == `HIPE_RST_VEC)
        else $error("unimplemented enable bit set");

    a_sena_keeps_undeleg: assert property (
        (csr_req.valid && csr_req.sel == HIPE_SEL_SENA) |=>
            ((enable_reg ^ $past(enable_reg)) & ~$past(dlg)) == `HIPE_RST_VEC)
        else $error("supervisor enable write hit undelegated bit");

    a_timer_below_m: assert property (
        (pend_view[`HIPE_BIT_MTI] && enable_reg[`HIPE_BIT_MTI] &&
            hart.priv != HIPE_PRIV_M) |=> irq_req)
        else $error("machine timer not taken below machine mode");

    if (!SUP_PRESENT) begin : g_nosup
        a_sup_bits_zero: assert property (
            ((pend_view | enable_reg) & `HIPE_S_MASK) == `HIPE_RST_VEC)
            else $error("supervisor bit set without supervisor");
    end

endmodule // hipe_core
`default_nettype wire

// file: tb/hipe_src_model.sv
// Purpose: interrupt sources beside the hart block: controller, timer, soft register
// Assumes: bench drives the controls on clk by non-blocking assignment
// Notes: timer posts while the count is at or past the compare value
`timescale 1ns/1ps
`default_nettype none
module hipe_src_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic ext_m,
    input wire logic ext_s,
    input wire logic cmp_we,
    input wire logic [15:0] cmp_wdata,
    input wire logic soft_we,
    input wire logic soft_wdata,
    output logic m_ext_irq,
    output logic s_ext_irq,
    output logic m_timer_irq,
    output logic m_soft_irq
);
    logic [15:0] time_reg;
    logic [15:0] cmp_reg;
    logic soft_reg;
    assign m_ext_irq = ext_m;
    assign s_ext_irq = ext_s;
    assign m_timer_irq = time_reg >= cmp_reg;
    assign m_soft_irq = soft_reg;
    always_ff @(posedge clk) begin
        if (srst) begin
            time_reg <= 16'h0000;
        end else begin
            time_reg <= time_reg + 16'h0001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_reg <= 16'hffff;
        end else if (cmp_we) begin
            cmp_reg <= cmp_wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            soft_reg <= 1'b0;
        end else if (soft_we) begin
            soft_reg <= soft_wdata;
        end
    end
endmodule // hipe_src_model
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench of the hart interrupt block
// Assumes: sources come from the partner model
// Notes: a second instance runs without supervisor mode
`timescale 1ns/1ps
`default_nettype none
module tb
    import hipe_pkg::*;
;
    typedef struct packed {
        logic [2:0] src;
        logic [15:0] sw;
        hipe_hart_t hart;
        logic [15:0] deleg;
        logic exc;
        logic req;
        logic [3:0] cause;
        logic take;
    } hipe_row_t;
    logic clk;
    logic srst;
    hipe_csr_req_t csr_req;
    hipe_hart_t hart;
    logic [15:0] deleg;
    logic exc_pending;
    logic ext_m, ext_s, cmp_we, soft_we, soft_wdata;
    logic [15:0] cmp_wdata;
    logic m_ext_irq, s_ext_irq, m_timer_irq, m_soft_irq;
    logic [15:0] csr_rdata;
    logic [15:0] ns_rdata;
    logic csr_rvalid, irq_req, exc_take;
    logic [3:0] irq_cause;
    int failures;
    int compares;
    // src bits: external, software, timer
    hipe_row_t rows [14] = '{
        '{3'h7, 16'h0222, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'hb, 1'b0},
        '{3'h3, 16'h0222, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h3, 1'b0},
        '{3'h1, 16'h0222, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h7, 1'b0},
        '{3'h0, 16'h0222, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h9, 1'b0},
        '{3'h0, 16'h0022, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h1, 1'b0},
        '{3'h0, 16'h0020, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h5, 1'b0},
        '{3'h7, 16'h0222, '{HIPE_PRIV_M, 1'b0, 1'b0}, 16'h0000, 1'b1, 1'b0, 4'h0, 1'b1},
        '{3'h1, 16'h0000, '{HIPE_PRIV_S, 1'b0, 1'b0}, 16'h0000, 1'b0, 1'b1, 4'h7, 1'b0},
        '{3'h0, 16'h0222, '{HIPE_PRIV_M, 1'b1, 1'b1}, 16'h0222, 1'b1, 1'b0, 4'h0, 1'b1},
        '{3'h1, 16'h0222, '{HIPE_PRIV_S, 1'b0, 1'b1}, 16'h0222, 1'b0, 1'b1, 4'h7, 1'b0},
        '{3'h0, 16'h0222, '{HIPE_PRIV_S, 1'b1, 1'b0}, 16'h0222, 1'b0, 1'b0, 4'h0, 1'b0},
        '{3'h0, 16'h0222, '{HIPE_PRIV_U, 1'b0, 1'b0}, 16'h0222, 1'b0, 1'b1, 4'h9, 1'b0},
        '{3'h0, 16'h0222, '{HIPE_PRIV_S, 1'b0, 1'b1}, 16'h0200, 1'b0, 1'b1, 4'h1, 1'b0},
        '{3'h0, 16'h0002, '{HIPE_PRIV_M, 1'b1, 1'b0}, 16'h0000, 1'b1, 1'b1, 4'h1, 1'b0}
    };

    hipe_src_model hipe_src_model_inst (.clk, .srst, .ext_m, .ext_s, .cmp_we, .cmp_wdata,
        .soft_we, .soft_wdata, .m_ext_irq, .s_ext_irq, .m_timer_irq, .m_soft_irq);
    hipe_core #(.SUP_PRESENT(1'b1)) hipe_core_inst (.clk, .srst, .csr_req, .csr_rdata,
        .csr_rvalid, .hart, .deleg, .m_ext_irq, .s_ext_irq, .m_timer_irq, .m_soft_irq,
        .exc_pending, .irq_req, .irq_cause, .exc_take);
    hipe_core #(.SUP_PRESENT(1'b0)) hipe_core_inst_nosup (.clk, .srst, .csr_req,
        .csr_rdata(ns_rdata), .csr_rvalid(), .hart, .deleg, .m_ext_irq, .s_ext_irq,
        .m_timer_irq, .m_soft_irq, .exc_pending, .irq_req(), .irq_cause(), .exc_take());

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic csr(input hipe_op_t op, input hipe_sel_t sel, input logic [15:0] wd);
        @(posedge clk);
        csr_req <= '{valid: 1'b1, op: op, sel: sel, wdata: wd};
        @(posedge clk);
        csr_req.valid <= 1'b0;
        #1;
        check(16'(csr_rvalid), 16'h0001);
    endtask

    // a set with no bits is a plain read
    task automatic rd(input hipe_sel_t sel);
        csr(HIPE_OP_SET, sel, 16'h0000);
    endtask

    task automatic src(input logic [2:0] s);
        @(posedge clk);
        ext_m <= s[2];
        soft_we <= 1'b1;
        soft_wdata <= s[1];
        cmp_we <= 1'b1;
        cmp_wdata <= s[0] ? 16'h0000 : 16'hffff;
        @(posedge clk);
        soft_we <= 1'b0;
        cmp_we <= 1'b0;
    endtask

    initial begin
        #20us;
        failures++;
        give_verdict();
    end

    initial begin
        failures = 0;
        compares = 0;
        srst = 1'b1;
        csr_req = '0;
        hart = '0;
        deleg = 16'h0000;
        exc_pending = 1'b0;
        {ext_m, ext_s, cmp_we, soft_we, soft_wdata} = 5'h00;
        cmp_wdata = 16'h0000;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1;
        check(16'(irq_req), 16'h0000);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0000);
        csr(HIPE_OP_WRITE, HIPE_SEL_ENA, 16'hffff);
        rd(HIPE_SEL_ENA);
        check(csr_rdata, 16'h0aaa);
        check(ns_rdata, 16'h0888);
        csr(HIPE_OP_WRITE, HIPE_SEL_PEND, 16'hffff);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0222);
        check(ns_rdata, 16'h0000);
        csr(HIPE_OP_WRITE, HIPE_SEL_PEND, 16'h0020);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0020);
        csr(HIPE_OP_CLEAR, HIPE_SEL_PEND, 16'h0020);
        src(3'h7);
        tick(3);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0888);
        csr(HIPE_OP_WRITE, HIPE_SEL_PEND, 16'h0000);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0888);
        src(3'h6);
        tick(3);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0808);
        src(3'h0);
        ext_s <= 1'b1;
        tick(3);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0200);
        csr(HIPE_OP_SET, HIPE_SEL_PEND, 16'h0002);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0202);
        @(posedge clk);
        ext_s <= 1'b0;
        tick(3);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0002);
        foreach (rows[i]) begin
            src(rows[i].src);
            csr(HIPE_OP_WRITE, HIPE_SEL_PEND, rows[i].sw);
            @(posedge clk);
            hart <= rows[i].hart;
            deleg <= rows[i].deleg;
            exc_pending <= rows[i].exc;
            tick(4);
            check(16'(irq_req), 16'(rows[i].req));
            check(16'(irq_cause), 16'(rows[i].cause));
            check(16'(exc_take), 16'(rows[i].take));
        end
        @(posedge clk);
        deleg <= 16'h0020;
        exc_pending <= 1'b0;
        csr(HIPE_OP_WRITE, HIPE_SEL_PEND, 16'h0222);
        rd(HIPE_SEL_SPEND);
        check(csr_rdata, 16'h0020);
        csr(HIPE_OP_WRITE, HIPE_SEL_SENA, 16'h0000);
        rd(HIPE_SEL_ENA);
        check(csr_rdata, 16'h0a8a);
        check(16'(irq_req), 16'h0001);
        check(16'(irq_cause), 16'h0009);
        // mid-run reset while a request is up
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(16'(irq_req), 16'h0000);
        check(16'(irq_cause), 16'h0000);
        check(16'(csr_rvalid), 16'h0000);
        @(posedge clk);
        srst <= 1'b0;
        rd(HIPE_SEL_ENA);
        check(csr_rdata, 16'h0000);
        rd(HIPE_SEL_PEND);
        check(csr_rdata, 16'h0000);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
